// File: dv/dps_checker.sv
`timescale 1ns/100ps
module dps_checker (
   input logic       clk,
   input logic       sys_rst,
   input logic       psel,
   input logic       penable,
   input logic       pready,
   input logic [1:0] ramp_phase,
   input logic       dc_link_over,
   input logic       accel_hold,
   input logic       const_reduce,
   input logic       decel_hold,
   input logic       output_cut,
   input logic       hold_last_freq,
   input logic       decel_to_stop,
   input logic       fault_flag
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_apb_zero_wait: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   a_ready_single: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_accel_phase: assert property (
      accel_hold |-> $past(ramp_phase) == 2'h1)
      else $error("accel hold outside acceleration");
   a_const_phase: assert property (
      const_reduce |-> $past(ramp_phase) == 2'h2)
      else $error("reduction outside constant run");
   a_decel_cause: assert property (
      decel_hold |-> $past(dc_link_over) && $past(ramp_phase) == 2'h3)
      else $error("decel hold without cause");
   a_decel_release: assert property (!dc_link_over |=> !decel_hold)
      else $error("decel hold not released");
   a_accel_release: assert property (
      ramp_phase != 2'h1 |=> !accel_hold)
      else $error("accel hold not released");
   a_loss_action_excl: assert property (
      !(hold_last_freq && decel_to_stop))
      else $error("two loss actions at once");
   a_cut_on_fault: assert property (
      $rose(fault_flag) |-> ##[0:2] output_cut)
      else $error("fault without output cut");
endmodule

bind dps_top dps_checker u_chk (.clk, .sys_rst, .psel, .penable, .pready,
   .ramp_phase, .dc_link_over, .accel_hold, .const_reduce, .decel_hold,
   .output_cut, .hold_last_freq, .decel_to_stop, .fault_flag);

// File: dv/dps_partner.sv
`timescale 1ns/100ps
module dps_partner (
   output logic [1:0]  ramp_phase,
   output logic [15:0] motor_current,
   output logic        dc_link_over,
   output logic        inv_overload_trip,
   output logic [2:0]  phase_open,
   output logic [11:0] voltage_ref_input,
   output logic [11:0] current_ref_input,
   output logic        comm_ref_valid,
   output logic        input_terminal_four,
   output logic        input_terminal_five
);
   initial begin
      {ramp_phase, motor_current, dc_link_over, inv_overload_trip} = '0;
      phase_open = 3'h0;
      {voltage_ref_input, current_ref_input} = {2{12'hFFF}};
      comm_ref_valid = 1'b1;
      input_terminal_four = 1'b0;
      input_terminal_five = 1'b1;
   end
endmodule

// File: dv/tb.sv
`timescale 1ns/100ps
`include "dps_consts.vh"
module tb;
   typedef struct packed {
      logic [2:0] mode; logic [7:0] lvl; logic [1:0] ph;
      logic [15:0] cur; logic dc; logic [3:0] exp;
   } dps_row_t;
   // Rows: mode, level, phase, current, dc over, {aux,dec,con,acc}
   dps_row_t rows [8] = '{'{3, 150, 1, 151, 0, 4'b1001},
      '{3, 150, 1, 150, 0, 0}, '{3, 150, 2, 151, 0, 4'b1010},
      '{3, 150, 3, 0, 1, 0}, '{7, 150, 3, 0, 1, 4'b1100},
      '{1, 20, 1, 31, 0, 4'b1001}, '{1, 20, 1, 30, 0, 0},
      '{6, 150, 1, 200, 0, 0}};
   logic clk, sys_rst, psel, penable, pwrite, pslverr, pready, r_err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r_dat;
   logic [1:0] ramp_phase;
   logic [15:0] motor_current;
   logic [11:0] voltage_ref_input, current_ref_input;
   logic [2:0] phase_open;
   logic dc_link_over, inv_overload_trip, comm_ref_valid;
   logic input_terminal_four, input_terminal_five, accel_hold, decel_hold;
   logic const_reduce, output_cut, hold_last_freq, decel_to_stop;
   logic fault_flag, aux_output_pin, fault_relay_contact;
   int fails = 0, n_tests = 0;

   dps_partner p (.ramp_phase, .motor_current, .dc_link_over,
      .inv_overload_trip, .phase_open, .voltage_ref_input,
      .current_ref_input, .comm_ref_valid, .input_terminal_four,
      .input_terminal_five);
   dps_top #(.WAIT_UNIT_CYCLES(4)) DUT (.clk, .sys_rst, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ramp_phase,
      .motor_current, .dc_link_over, .inv_overload_trip, .phase_open,
      .voltage_ref_input, .current_ref_input, .comm_ref_valid,
      .input_terminal_four, .input_terminal_five, .accel_hold,
      .const_reduce, .decel_hold, .output_cut, .hold_last_freq,
      .decel_to_stop, .fault_flag, .aux_output_pin, .fault_relay_contact);

   always #10 clk = ~clk;

   task complete_run;
      $display("Comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
      @(posedge clk);
      penable <= 1;
      do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin fails++; complete_run; end
      r_dat = prdata; r_err = pslverr;
      psel <= 0; penable <= 0;
      @(posedge clk);
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   initial begin
      clk = 0; sys_rst = 1; {psel, penable, pwrite, paddr, pwdata} = '0;
      cyc(12);
      sys_rst <= 0;
      cyc(1);
      chk({output_cut, fault_flag, accel_hold, decel_to_stop}, 0);
      apb(0, `DPS_OFS_STALL, 0); chk(r_dat, 32'h0000_9603);
      apb(0, `DPS_OFS_PROT, 0); chk(r_dat, 0);
      apb(0, `DPS_OFS_WAIT, 0); chk(r_dat, 32'h0A);
      apb(0, 8'h20, 0); chk(r_err, 1);
      apb(1, `DPS_OFS_IOFUNC, 32'h1312_0B07);
      foreach (rows[i]) begin
         apb(1, `DPS_OFS_STALL, {16'h0, rows[i].lvl, 5'h0, rows[i].mode});
         p.ramp_phase <= rows[i].ph; p.motor_current <= rows[i].cur;
         p.dc_link_over <= rows[i].dc;
         cyc(4);
         chk({aux_output_pin, decel_hold, const_reduce, accel_hold},
            rows[i].exp);
         p.ramp_phase <= 0; p.motor_current <= 0; p.dc_link_over <= 0;
         cyc(1);
      end
      // External trips: contact four closes, then contact five opens
      for (int k = 0; k < 2; k++) begin
         if (k == 0) p.input_terminal_four <= 1;
         else p.input_terminal_five <= 0;
         cyc(6);
         chk({fault_flag, output_cut}, 2'b11);
         p.input_terminal_four <= 0; p.input_terminal_five <= 1;
         cyc(5); apb(1, `DPS_OFS_FCLR, 2); cyc(3);
         chk({fault_flag, output_cut}, 0);
      end
      p.ramp_phase <= 2; p.phase_open <= 3'h2; cyc(6);
      chk(output_cut, 0);
      apb(1, `DPS_OFS_PROT, 1); cyc(4);
      chk({fault_flag, output_cut}, 2'b11);
      p.ramp_phase <= 0; p.phase_open <= 0; cyc(5);
      apb(1, `DPS_OFS_FCLR, 1);
      apb(1, `DPS_OFS_REFMIN, 32'd100); apb(1, `DPS_OFS_WAIT, 2);
      for (int a = 0; a < 5; a++) begin
         apb(1, `DPS_OFS_PROT, a < 3 ? 32'h104 | (a << 4) : 32'h144 - a*32);
         p.voltage_ref_input <= 49; cyc(14);
         chk({hold_last_freq, output_cut, decel_to_stop, fault_relay_contact},
            a < 3 ? {a == 0, a == 1, a == 2, 1'b1} : 0);
         p.voltage_ref_input <= 12'hFFF; cyc(4);
      end
      apb(1, `DPS_OFS_PROT, 32'h124);
      p.voltage_ref_input <= 49; cyc(6); chk(decel_to_stop, 0);
      p.voltage_ref_input <= 50; cyc(1);
      p.voltage_ref_input <= 49; cyc(7); chk(decel_to_stop, 0);
      cyc(8); chk({decel_to_stop, fault_relay_contact}, 2'b11);
      // Summed source, criterion 2: current input under its own minimum
      p.voltage_ref_input <= 12'hFFF; p.current_ref_input <= 99;
      apb(1, `DPS_OFS_REFMIN, 32'h0064_0064); apb(1, `DPS_OFS_PROT, 32'h318);
      cyc(14); chk(output_cut, 1);
      apb(1, `DPS_OFS_IOFUNC, 32'h1312_0B06);
      p.inv_overload_trip <= 1; cyc(4); chk(aux_output_pin, 1);
      // Reset in mid-run: actions drop, settings back to defaults
      sys_rst <= 1; cyc(3); sys_rst <= 0; cyc(2);
      chk({aux_output_pin, fault_relay_contact, output_cut}, 3'b010);
      apb(0, `DPS_OFS_IOFUNC, 0); chk(r_dat, 32'h0403_110C);
      complete_run;
   end
endmodule

// File: rtl/dps_sync.v
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Two-stage synchroniser, one per bit
// ----------------------------------------------------------------------
module dps_sync #(
   parameter W = 1
) (
   input  wire         clk,
   input  wire         sys_rst,
   input  wire [W-1:0] din,
   output wire [W-1:0] dout
);

   genvar g;
   generate
      for (g = 0; g < W; g = g + 1) begin : g_bit
         reg meta_q;
         reg sync_q;
         always @(posedge clk) begin
            if (sys_rst) begin
               meta_q <= 1'b0;
               sync_q <= 1'b0;
            end else begin
               meta_q <= din[g];
               sync_q <= meta_q;
            end
         end
         assign dout[g] = sync_q;
      end
   endgenerate

endmodule

// File: rtl/dps_top.v
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
// Notes on behaviour
// - Accel stall on: stop speed rise while current over level.
// - Constant-speed stall on: lower frequency while current over level.
// - Decel stall on: pause slowdown while DC link is too high.
// - Stall level is percent of rated current, range 30..150, default 150.
// - Stall mode mask: bit0 accel, bit1 constant, bit2 decel; default 3.
// - Output selected to stall code asserts while stall prevention acts.
// - Stall holds stretch the ramp beyond programmed accel or decel time.
// - Phase loss enable 1 cuts output on output phase loss; default 0.
// - Input function 18: closed contact flags fault and cuts output.
// - Input function 19: opened contact flags fault and cuts output.
// - Output pin or relay signals inverter overload trip when selected.
// - Ref loss checked only for voltage, current, sum or comm source.
// - Loss criterion 0..2; zero disables analog loss check, default 0.
// - Criterion 1: lost when analog input under half its minimum.
// - Criterion 2 with sum: lost when either input below its minimum.
// - Loss action only after wait time without command; default 1.0 s.
// - Loss action: 0 keep last frequency, 1 coast, 2 ramp to stop.
// - Output selected to code 11 reports frequency command loss.
// - Output function code 7 selects motor stall indication.
`include "dps_consts.vh"
module dps_top #(
   parameter WAIT_UNIT_CYCLES = `DPS_WAIT_UNIT_NS / `DPS_CLK_NS
) (
   input  wire        clk,
   input  wire        sys_rst,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Power stage measurements and ramp state
   input  wire [1:0]  ramp_phase,
   input  wire [15:0] motor_current,
   input  wire        dc_link_over,
   input  wire        inv_overload_trip,
   input  wire [2:0]  phase_open,
   // Reference sources
   input  wire [11:0] voltage_ref_input,
   input  wire [11:0] current_ref_input,
   input  wire        comm_ref_valid,
   // Contact inputs
   input  wire        input_terminal_four,
   input  wire        input_terminal_five,
   // Drive controls and status outputs
   output reg         accel_hold,
   output reg         const_reduce,
   output reg         decel_hold,
   output reg         output_cut,
   output reg         hold_last_freq,
   output reg         decel_to_stop,
   output reg         fault_flag,
   output reg         aux_output_pin,
   output reg         fault_relay_contact
);

   // ----------------------------------------------------------------------
   // Constants
   // ----------------------------------------------------------------------
   localparam [31:0] UNIT_CNT = (WAIT_UNIT_CYCLES < 1) ? 32'd1 :
                                WAIT_UNIT_CYCLES;
   localparam [1:0]  RL_IDLE  = 2'd0;
   localparam [1:0]  RL_WAIT  = 2'd1;
   localparam [1:0]  RL_LOST  = 2'd2;

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   wire [4:0] pins_s;

   dps_sync #(
      .W (5)
   ) u_sync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .din     ({phase_open, input_terminal_five, input_terminal_four}),
      .dout    (pins_s)
   );

   wire       term4_s    = pins_s[0];
   wire       term5_s    = pins_s[1];
   wire [2:0] ph_open_s  = pins_s[4:2];

   // ----------------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------------
   reg  [2:0]  stall_mode_select_q;
   reg  [7:0]  stall_current_level_q;
   reg  [15:0] motor_rated_current_q;
   reg  [4:0]  aux_output_function_q;
   reg  [4:0]  relay_function_q;
   reg  [4:0]  input_four_function_q;
   reg  [4:0]  input_five_function_q;
   reg         phase_loss_enable_q;
   reg  [1:0]  ref_loss_criterion_q;
   reg  [1:0]  ref_loss_action_q;
   reg  [2:0]  ref_source_q;
   reg  [7:0]  ref_loss_wait_q;
   reg  [11:0] volt_min_q;
   reg  [11:0] curr_min_q;

   reg         phase_trip_q;
   reg         ext_trip_q;
   reg         ext_trip_d;
   reg         stall_active_q;
   reg  [1:0]  rl_state_q;
   reg  [1:0]  rl_state_d;

   wire        setup_rd = psel & ~penable & ~pwrite;
   wire        acc_done = psel & penable & pready;
   wire        wr_en    = acc_done & pwrite;
   wire [7:0]  lvl_wr   = pwdata[`DPS_STALL_LVL_LSB +: 8];
   wire        fclr_wr  = wr_en & (paddr == `DPS_OFS_FCLR);

   always @(posedge clk) begin
      if (sys_rst) begin
         stall_mode_select_q   <= `DPS_RST_STALL_MODE;
         stall_current_level_q <= `DPS_RST_STALL_LVL;
         motor_rated_current_q <= `DPS_RST_RATED;
         aux_output_function_q <= `DPS_RST_AUX_FN;
         relay_function_q      <= `DPS_RST_RLY_FN;
         input_four_function_q <= `DPS_RST_IN4_FN;
         input_five_function_q <= `DPS_RST_IN5_FN;
         phase_loss_enable_q   <= `DPS_RST_PL_EN;
         ref_loss_criterion_q  <= `DPS_RST_CRIT;
         ref_loss_action_q     <= `DPS_RST_ACT;
         ref_source_q          <= `DPS_RST_SRC;
         ref_loss_wait_q       <= `DPS_RST_WAIT;
         volt_min_q            <= `DPS_RST_VMIN;
         curr_min_q            <= `DPS_RST_IMIN;
      end else if (wr_en) begin
         case (paddr)
            `DPS_OFS_STALL: begin
               stall_mode_select_q <=
                  pwdata[`DPS_STALL_MODE_LSB +: 3];
               // Level clamped into its legal span
               if (lvl_wr < `DPS_STALL_LVL_MIN) begin
                  stall_current_level_q <= `DPS_STALL_LVL_MIN;
               end else if (lvl_wr > `DPS_STALL_LVL_MAX) begin
                  stall_current_level_q <= `DPS_STALL_LVL_MAX;
               end else begin
                  stall_current_level_q <= lvl_wr;
               end
            end
            `DPS_OFS_RATED: begin
               motor_rated_current_q <= pwdata[15:0];
            end
            `DPS_OFS_IOFUNC: begin
               aux_output_function_q <= pwdata[`DPS_AUX_FN_LSB +: 5];
               relay_function_q      <= pwdata[`DPS_RLY_FN_LSB +: 5];
               input_four_function_q <= pwdata[`DPS_IN4_FN_LSB +: 5];
               input_five_function_q <= pwdata[`DPS_IN5_FN_LSB +: 5];
            end
            `DPS_OFS_PROT: begin
               phase_loss_enable_q <= pwdata[`DPS_PL_EN_BIT];
               // Values above 2 are refused, old setting kept
               if (pwdata[`DPS_CRIT_LSB +: 2] != 2'd3) begin
                  ref_loss_criterion_q <= pwdata[`DPS_CRIT_LSB +: 2];
               end
               if (pwdata[`DPS_ACT_LSB +: 2] != 2'd3) begin
                  ref_loss_action_q <= pwdata[`DPS_ACT_LSB +: 2];
               end
               ref_source_q <= pwdata[`DPS_SRC_LSB +: 3];
            end
            `DPS_OFS_WAIT: begin
               ref_loss_wait_q <= pwdata[7:0];
            end
            `DPS_OFS_REFMIN: begin
               volt_min_q <= pwdata[`DPS_VMIN_LSB +: 12];
               curr_min_q <= pwdata[`DPS_IMIN_LSB +: 12];
            end
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // APB answer: one wait-free access cycle
   // ----------------------------------------------------------------------
   wire mapped = (paddr[1:0] == 2'b00) && (paddr <= `DPS_OFS_FCLR);

   always @(posedge clk) begin
      if (sys_rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         if (setup_rd) begin
            case (paddr)
               `DPS_OFS_STALL:  prdata <= {16'h0000, stall_current_level_q,
                                           5'h00, stall_mode_select_q};
               `DPS_OFS_RATED:  prdata <= {16'h0000, motor_rated_current_q};
               `DPS_OFS_IOFUNC: prdata <= {3'h0, input_five_function_q,
                                           3'h0, input_four_function_q,
                                           3'h0, relay_function_q,
                                           3'h0, aux_output_function_q};
               `DPS_OFS_PROT:   prdata <= {21'h000000, ref_source_q, 2'h0,
                                           ref_loss_action_q,
                                           ref_loss_criterion_q,
                                           1'b0, phase_loss_enable_q};
               `DPS_OFS_WAIT:   prdata <= {24'h000000, ref_loss_wait_q};
               `DPS_OFS_REFMIN: prdata <= {4'h0, curr_min_q,
                                           4'h0, volt_min_q};
               `DPS_OFS_STATUS: prdata <= {24'h000000,
                                           inv_overload_trip,
                                           (rl_state_q == RL_LOST),
                                           ext_trip_q, phase_trip_q,
                                           decel_hold, const_reduce,
                                           accel_hold, stall_active_q};
               default:         prdata <= 32'h00000000;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // Stall prevention
   // ----------------------------------------------------------------------
   wire [23:0] cur_x100  = {8'h00, motor_current} * `DPS_PCT_SCALE;
   wire [23:0] stall_lim = {8'h00, motor_rated_current_q} *
                           {16'h0000, stall_current_level_q};
   wire        over_i    = cur_x100 > stall_lim;

   wire acc_h_d = stall_mode_select_q[0] & (ramp_phase == `DPS_PH_ACCEL)
                  & over_i;
   wire con_r_d = stall_mode_select_q[1] & (ramp_phase == `DPS_PH_CONST)
                  & over_i;
   wire dec_h_d = stall_mode_select_q[2] & (ramp_phase == `DPS_PH_DECEL)
                  & dc_link_over;

   // Re-evaluated every cycle, so each hold drops one cycle after its cause does
   always @(posedge clk) begin
      if (sys_rst) begin
         accel_hold     <= 1'b0;
         const_reduce   <= 1'b0;
         decel_hold     <= 1'b0;
         stall_active_q <= 1'b0;
      end else begin
         accel_hold     <= acc_h_d;
         const_reduce   <= con_r_d;
         decel_hold     <= dec_h_d;
         stall_active_q <= acc_h_d | con_r_d | dec_h_d;
      end
   end

   // ----------------------------------------------------------------------
   // Phase loss and external trips
   // ----------------------------------------------------------------------
   wire running   = (ramp_phase != 2'b00);
   wire ph_loss   = phase_loss_enable_q & running & (|ph_open_s);

   wire ext_a4 = (input_four_function_q == `DPS_IN_EXT_A) & term4_s;
   wire ext_a5 = (input_five_function_q == `DPS_IN_EXT_A) & term5_s;
   wire ext_b4 = (input_four_function_q == `DPS_IN_EXT_B) & ~term4_s;
   wire ext_b5 = (input_five_function_q == `DPS_IN_EXT_B) & ~term5_s;
   wire ext_now = ext_a4 | ext_a5 | ext_b4 | ext_b5;

   // Trips latch; a clear cannot beat a live cause
   always @* begin
      ext_trip_d = ext_trip_q;
      if (fclr_wr && pwdata[1]) begin
         ext_trip_d = 1'b0;
      end
      if (ext_now) begin
         ext_trip_d = 1'b1;
      end
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         phase_trip_q <= 1'b0;
         ext_trip_q   <= 1'b0;
      end else begin
         ext_trip_q <= ext_trip_d;
         if (ph_loss) begin
            phase_trip_q <= 1'b1;
         end else if (fclr_wr && pwdata[0]) begin
            phase_trip_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Reference loss detection
   // ----------------------------------------------------------------------
   wire [11:0] vmin_half = {1'b0, volt_min_q[11:1]};
   wire [11:0] imin_half = {1'b0, curr_min_q[11:1]};
   wire v_low = (ref_loss_criterion_q == 2'd1) ?
                (voltage_ref_input < vmin_half) :
                (voltage_ref_input < volt_min_q);
   wire i_low = (ref_loss_criterion_q == 2'd1) ?
                (current_ref_input < imin_half) :
                (current_ref_input < curr_min_q);
   reg  cause;

   always @* begin
      cause = 1'b0;
      if (ref_loss_criterion_q != 2'd0) begin
         case (ref_source_q)
            `DPS_SRC_VOLT: cause = v_low;
            `DPS_SRC_CURR: cause = i_low;
            `DPS_SRC_SUM:  cause = v_low | i_low;
            `DPS_SRC_COMM: cause = ~comm_ref_valid;
            default:       cause = 1'b0;
         endcase
      end
   end

   // Wait time counted in 0.1 s units from a divider enable
   reg  [31:0] div_q;
   reg  [7:0]  units_q;
   wire        unit_tick = (div_q == UNIT_CNT - 32'd1);
   wire        waited    = (units_q >= ref_loss_wait_q);

   always @* begin
      rl_state_d = rl_state_q;
      case (rl_state_q)
         RL_IDLE: begin
            if (cause) begin
               rl_state_d = RL_WAIT;
            end
         end
         RL_WAIT: begin
            if (!cause) begin
               rl_state_d = RL_IDLE;
            end else if (waited) begin
               rl_state_d = RL_LOST;
            end
         end
         RL_LOST: begin
            if (!cause) begin
               rl_state_d = RL_IDLE;
            end
         end
         default: rl_state_d = RL_IDLE;
      endcase
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         rl_state_q <= RL_IDLE;
         div_q      <= 32'h00000000;
         units_q    <= 8'h00;
      end else begin
         rl_state_q <= rl_state_d;
         if (rl_state_q != RL_WAIT || !cause) begin
            div_q   <= 32'h00000000;
            units_q <= 8'h00;
         end else if (unit_tick) begin
            div_q <= 32'h00000000;
            if (!waited) begin
               units_q <= units_q + 8'h01;
            end
         end else begin
            div_q <= div_q + 32'h00000001;
         end
      end
   end

   wire ref_lost = (rl_state_q == RL_LOST);

   // ----------------------------------------------------------------------
   // Drive controls and status outputs
   // ----------------------------------------------------------------------
   function fn_out;
      input [4:0] code;
      input       stall;
      input       iol;
      input       loss;
      input       run;
      input       flt;
      begin
         case (code)
            `DPS_FN_IOL:      fn_out = iol;
            `DPS_FN_STALL:    fn_out = stall;
            `DPS_FN_CMD_LOSS: fn_out = loss;
            `DPS_FN_RUN:      fn_out = run;
            `DPS_FN_FAULT:    fn_out = flt;
            default:          fn_out = 1'b0;
         endcase
      end
   endfunction

   wire any_fault = phase_trip_q | ext_trip_q | inv_overload_trip;

   always @(posedge clk) begin
      if (sys_rst) begin
         output_cut          <= 1'b0;
         hold_last_freq      <= 1'b0;
         decel_to_stop       <= 1'b0;
         fault_flag          <= 1'b0;
         aux_output_pin      <= 1'b0;
         fault_relay_contact <= 1'b0;
      end else begin
         output_cut     <= phase_trip_q | ext_trip_q |
                           (ref_lost &
                            (ref_loss_action_q == `DPS_ACT_COAST));
         hold_last_freq <= ref_lost &
                           (ref_loss_action_q == `DPS_ACT_CONT);
         decel_to_stop  <= ref_lost &
                           (ref_loss_action_q == `DPS_ACT_DECEL);
         fault_flag     <= phase_trip_q | ext_trip_q;
         aux_output_pin <= fn_out(aux_output_function_q, stall_active_q,
                                  inv_overload_trip, ref_lost, running,
                                  any_fault);
         fault_relay_contact <= fn_out(relay_function_q, stall_active_q,
                                       inv_overload_trip, ref_lost, running,
                                       any_fault);
      end
   end

endmodule

// File: shared/dps_consts.vh
`ifndef DPS_CONSTS_VH
`define DPS_CONSTS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define DPS_OFS_STALL      8'h00
`define DPS_OFS_RATED      8'h04
`define DPS_OFS_IOFUNC     8'h08
`define DPS_OFS_PROT       8'h0C
`define DPS_OFS_WAIT       8'h10
`define DPS_OFS_REFMIN     8'h14
`define DPS_OFS_STATUS     8'h18
`define DPS_OFS_FCLR       8'h1C

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define DPS_STALL_MODE_LSB 0
`define DPS_STALL_LVL_LSB  8
`define DPS_AUX_FN_LSB     0
`define DPS_RLY_FN_LSB     8
`define DPS_IN4_FN_LSB     16
`define DPS_IN5_FN_LSB     24
`define DPS_PL_EN_BIT      0
`define DPS_CRIT_LSB       2
`define DPS_ACT_LSB        4
`define DPS_SRC_LSB        8
`define DPS_VMIN_LSB       0
`define DPS_IMIN_LSB       16

// ----------------------------------------------------------------------
// Reset values and stall level limits
// ----------------------------------------------------------------------
`define DPS_RST_STALL_MODE 3'h3
`define DPS_RST_STALL_LVL  8'h96
`define DPS_STALL_LVL_MIN  8'h1E
`define DPS_STALL_LVL_MAX  8'h96
`define DPS_RST_RATED      16'h0064
`define DPS_RST_AUX_FN     5'h0C
`define DPS_RST_RLY_FN     5'h11
`define DPS_RST_IN4_FN     5'h03
`define DPS_RST_IN5_FN     5'h04
`define DPS_RST_PL_EN      1'b0
`define DPS_RST_CRIT       2'h0
`define DPS_RST_ACT        2'h0
`define DPS_RST_SRC        3'h0
`define DPS_RST_WAIT       8'h0A
`define DPS_RST_VMIN       12'h000
`define DPS_RST_IMIN       12'h000

// ----------------------------------------------------------------------
// Codes
// ----------------------------------------------------------------------
`define DPS_FN_IOL         5'h06
`define DPS_FN_STALL       5'h07
`define DPS_FN_CMD_LOSS    5'h0B
`define DPS_FN_RUN         5'h0C
`define DPS_FN_FAULT       5'h11
`define DPS_IN_EXT_A       5'h12
`define DPS_IN_EXT_B       5'h13
`define DPS_SRC_VOLT       3'h1
`define DPS_SRC_CURR       3'h2
`define DPS_SRC_SUM        3'h3
`define DPS_SRC_COMM       3'h4
`define DPS_PH_ACCEL       2'h1
`define DPS_PH_CONST       2'h2
`define DPS_PH_DECEL       2'h3
`define DPS_ACT_CONT       2'h0
`define DPS_ACT_COAST      2'h1
`define DPS_ACT_DECEL      2'h2
`define DPS_PCT_SCALE      24'd100

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define DPS_CLK_NS         20
`define DPS_WAIT_UNIT_NS   100000000

`endif
